// File: include/csrb_pkg.sv
package csrb_pkg;
    // file addresses, full 8-bit operand address
    localparam logic [7:0] CSRB_A_INDF0    = 8'h00;
    localparam logic [7:0] CSRB_A_PCL0     = 8'h02;
    localparam logic [7:0] CSRB_A_STATUS0  = 8'h03;
    localparam logic [7:0] CSRB_A_FSR0     = 8'h04;
    localparam logic [7:0] CSRB_A_PCLATH0  = 8'h0a;
    localparam logic [7:0] CSRB_A_INTCON0  = 8'h0b;
    localparam logic [7:0] CSRB_A_PIR      = 8'h0c;
    localparam logic [7:0] CSRB_A_COMPARATOR_CONFIG    = 8'h1f;
    localparam logic [7:0] CSRB_A_INDF1    = 8'h80;
    localparam logic [7:0] CSRB_A_OPTION   = 8'h81;
    localparam logic [7:0] CSRB_A_PCL1     = 8'h82;
    localparam logic [7:0] CSRB_A_STATUS1  = 8'h83;
    localparam logic [7:0] CSRB_A_FSR1     = 8'h84;
    localparam logic [7:0] CSRB_A_PORT_A_DIRECTION    = 8'h85;
    localparam logic [7:0] CSRB_A_PORT_B_DIRECTION    = 8'h86;
    localparam logic [7:0] CSRB_A_PCLATH1  = 8'h8a;
    localparam logic [7:0] CSRB_A_INTCON1  = 8'h8b;
    localparam logic [7:0] CSRB_A_PIE      = 8'h8c;
    localparam logic [7:0] CSRB_A_POWER_RESET_FLAGS     = 8'h8e;
    localparam logic [7:0] CSRB_A_VOLTAGE_REF_CONFIG    = 8'h9f;
    // status bit positions
    localparam int CSRB_B_C    = 0;
    localparam int CSRB_B_DC   = 1;
    localparam int CSRB_B_Z    = 2;
    localparam int CSRB_B_PD   = 3;
    localparam int CSRB_B_TO   = 4;
    localparam int CSRB_B_RP0  = 5;
    // writable-bit masks of implemented registers
    localparam logic [7:0] CSRB_M_PIR    = 8'h40;
    localparam logic [7:0] CSRB_M_COMPARATOR_CONFIG  = 8'h0f;
    localparam logic [7:0] CSRB_M_PROGRAM_COUNTER_HIGH_LATCH = 8'h1f;
    localparam logic [7:0] CSRB_M_PORT_A_DIRECTION  = 8'h1f;
    localparam logic [7:0] CSRB_M_POWER_RESET_FLAGS   = 8'h03;
    localparam logic [7:0] CSRB_M_VOLTAGE_REF_CONFIG  = 8'hef;
    localparam logic [7:0] CSRB_M_STATUS = 8'he7;
    // reset values
    localparam logic [7:0] CSRB_R_OPTION = 8'hff;
    localparam logic [7:0] CSRB_R_PORT_A_DIRECTION  = 8'h1f;
    localparam logic [7:0] CSRB_R_PORT_B_DIRECTION  = 8'hff;
    localparam logic [7:0] CSRB_R_ZERO   = 8'h00;
    localparam logic [2:0] CSRB_R_STHI   = 3'h0;
    localparam logic [7:0] CSRB_BANK_SPAN = 8'h80;

    // alu operation selector
    typedef enum logic [3:0] {
        CSRB_OP_NONE = 4'h0,
        CSRB_OP_ADD  = 4'h1,
        CSRB_OP_SUB  = 4'h2,
        CSRB_OP_AND  = 4'h3,
        CSRB_OP_IOR  = 4'h4,
        CSRB_OP_XOR  = 4'h5,
        CSRB_OP_RRF  = 4'h6,
        CSRB_OP_RLF  = 4'h7,
        CSRB_OP_CLR  = 4'h8,
        CSRB_OP_MOVE = 4'h9,
        CSRB_OP_PASS = 4'ha
    } csrb_op_type;

    // one execute-cycle request from the datapath
    typedef struct packed {
        logic        valid;
        csrb_op_type op;
        logic        set_z;
        logic [7:0]  a;
        logic [7:0]  b;
        logic [7:0]  dest;
        logic        write_file;
    } csrb_req_type;

    // alu result and flags
    typedef struct packed {
        logic [7:0] value;
        logic       z;
        logic       dc;
        logic       c;
        logic       uses_c;
        logic       uses_dc;
    } csrb_alu_type;

    // core events
    typedef struct packed {
        logic wdt_timeout;
        logic wdt_clear;
        logic sleep;
    } csrb_evt_type;
endpackage

// File: rtl/csrb_alu.sv
module csrb_alu
    import csrb_pkg::*;
(
    // operation
    input  csrb_pkg::csrb_op_type op,
    input  logic [7:0]            a,
    input  logic [7:0]            b,
    input  logic                  c_in,
    // result
    output csrb_pkg::csrb_alu_type res
);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] b_eff;

    // subtraction adds the two's complement, so carry is an inverted borrow
    always_comb begin
        b_eff = (op == CSRB_OP_SUB) ? ~b : b;
        full  = {1'b0, a} + {1'b0, b_eff} + {8'h00, (op == CSRB_OP_SUB)};
        low   = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, (op == CSRB_OP_SUB)};
        res   = '0;
        unique case (op)
            CSRB_OP_ADD, CSRB_OP_SUB: begin
                res.value   = full[7:0];
                res.c       = full[8];
                res.dc      = low[4];
                res.uses_c  = 1'b1;
                res.uses_dc = 1'b1;
            end
            CSRB_OP_AND:  res.value = a & b;
            CSRB_OP_IOR:  res.value = a | b;
            CSRB_OP_XOR:  res.value = a ^ b;
            CSRB_OP_RRF: begin
                res.value  = {c_in, a[7:1]};
                res.c      = a[0];
                res.uses_c = 1'b1;
            end
            CSRB_OP_RLF: begin
                res.value  = {a[6:0], c_in};
                res.c      = a[7];
                res.uses_c = 1'b1;
            end
            CSRB_OP_CLR:  res.value = 8'h00;
            default:      res.value = a;
        endcase
        res.z = (res.value == 8'h00);
    end
endmodule // csrb_alu

// File: rtl/csrb_core_regs.sv
module csrb_core_regs
    import csrb_pkg::*;
(
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   por_n,
    // execute request
    input  wire csrb_pkg::csrb_req_type req,
    input  wire csrb_pkg::csrb_evt_type evt,
    // operand read port
    input  wire logic [7:0]             rd_addr,
    output logic [7:0]                  rd_data,
    // core state
    output logic [7:0]                  status_out,
    output logic [7:0]                  option_out,
    output logic [7:0]                  fsr_out,
    output logic [7:0]                  program_counter_high_latch_out,
    output logic [7:0]                  result_out,
    output logic                        bank_hi,
    output logic                        prescaler_assign
);
    import csrb_pkg::*;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] option;
        logic [7:0] indirect_pointer;
        logic [7:0] program_counter_low;
        logic [7:0] program_counter_high_latch;
        logic [7:0] interrupt_control;
        logic [7:0] pir;
        logic [7:0] pie;
        logic [7:0] comparator_config;
        logic [7:0] port_a_direction;
        logic [7:0] port_b_direction;
        logic [7:0] power_reset_flags;
        logic [7:0] voltage_ref_config;
        logic [7:0] rd;
        logic [7:0] result;
    } csrb_state_type;

    csrb_state_type s_q;
    csrb_state_type s_d;
    csrb_alu_type   alu;

    // map a status-bank address to its bank-0 alias
    function automatic logic [7:0] csrb_mirror(input logic [7:0] addr);
        if (addr == CSRB_A_STATUS1 || addr == CSRB_A_PCL1 || addr == CSRB_A_FSR1
            || addr == CSRB_A_PCLATH1 || addr == CSRB_A_INTCON1 || addr == CSRB_A_INDF1)
            csrb_mirror = addr & ~CSRB_BANK_SPAN;
        else
            csrb_mirror = addr;
    endfunction

    // read decode, unimplemented places give zero
    function automatic logic [7:0] csrb_read(input csrb_state_type st, input logic [7:0] addr);
        unique case (csrb_mirror(addr))
            CSRB_A_STATUS0: csrb_read = st.status;
            CSRB_A_PCL0:    csrb_read = st.program_counter_low;
            CSRB_A_FSR0:    csrb_read = st.indirect_pointer;
            CSRB_A_PCLATH0: csrb_read = st.program_counter_high_latch & CSRB_M_PROGRAM_COUNTER_HIGH_LATCH;
            CSRB_A_INTCON0: csrb_read = st.interrupt_control;
            CSRB_A_PIR:     csrb_read = st.pir & CSRB_M_PIR;
            CSRB_A_COMPARATOR_CONFIG:   csrb_read = st.comparator_config & 8'hcf;
            CSRB_A_OPTION:  csrb_read = st.option;
            CSRB_A_PORT_A_DIRECTION:   csrb_read = st.port_a_direction & CSRB_M_PORT_A_DIRECTION;
            CSRB_A_PORT_B_DIRECTION:   csrb_read = st.port_b_direction;
            CSRB_A_PIE:     csrb_read = st.pie & CSRB_M_PIR;
            CSRB_A_POWER_RESET_FLAGS:    csrb_read = st.power_reset_flags & CSRB_M_POWER_RESET_FLAGS;
            CSRB_A_VOLTAGE_REF_CONFIG:   csrb_read = st.voltage_ref_config & CSRB_M_VOLTAGE_REF_CONFIG;
            default:        csrb_read = 8'h00;
        endcase
    endfunction

    csrb_alu u_alu (
        .op   (req.op),
        .a    (req.a),
        .b    (req.b),
        .c_in (s_q.status[CSRB_B_C]),
        .res  (alu)
    );

    // next-state logic: file write, then flag updates, then events
    always_comb begin
        logic [7:0] dst;
        logic [7:0] wv;
        logic       flag_op;
        dst        = csrb_mirror(req.dest);
        wv         = alu.value;
        flag_op    = req.set_z | alu.uses_c | alu.uses_dc;
        s_d        = s_q;
        s_d.rd     = csrb_read(s_q, rd_addr);
        if (req.valid) begin
            s_d.result = alu.value;
            if (req.write_file) begin
                unique case (dst)
                    CSRB_A_STATUS0: begin
                        // only bank bits and, for flagless ops, result flags take the write
                        s_d.status[7:5] = wv[7:5];
                        if (!flag_op)
                            s_d.status[2:0] = wv[2:0];
                    end
                    CSRB_A_PCL0:    s_d.program_counter_low    = wv;
                    CSRB_A_FSR0:    s_d.indirect_pointer    = wv;
                    CSRB_A_PCLATH0: s_d.program_counter_high_latch = wv & CSRB_M_PROGRAM_COUNTER_HIGH_LATCH;
                    CSRB_A_INTCON0: s_d.interrupt_control = wv;
                    CSRB_A_PIR:     s_d.pir    = wv & CSRB_M_PIR;
                    CSRB_A_COMPARATOR_CONFIG:   s_d.comparator_config  = (s_q.comparator_config & 8'hc0) | (wv & CSRB_M_COMPARATOR_CONFIG);
                    CSRB_A_OPTION:  s_d.option = wv;
                    CSRB_A_PORT_A_DIRECTION:   s_d.port_a_direction  = wv & CSRB_M_PORT_A_DIRECTION;
                    CSRB_A_PORT_B_DIRECTION:   s_d.port_b_direction  = wv;
                    CSRB_A_PIE:     s_d.pie    = wv & CSRB_M_PIR;
                    CSRB_A_POWER_RESET_FLAGS:    s_d.power_reset_flags   = wv & CSRB_M_POWER_RESET_FLAGS;
                    CSRB_A_VOLTAGE_REF_CONFIG:   s_d.voltage_ref_config  = wv & CSRB_M_VOLTAGE_REF_CONFIG;
                    default:        s_d.rd     = s_d.rd;
                endcase
            end
            // flags from the operation override any written value
            if (req.set_z)
                s_d.status[CSRB_B_Z] = alu.z;
            if (alu.uses_c)
                s_d.status[CSRB_B_C] = alu.c;
            if (alu.uses_dc)
                s_d.status[CSRB_B_DC] = alu.dc;
        end
        // hardware events; timeout wins over a same-cycle clear
        if (evt.wdt_clear) begin
            s_d.status[CSRB_B_TO] = 1'b1;
            s_d.status[CSRB_B_PD] = 1'b1;
        end
        if (evt.sleep) begin
            s_d.status[CSRB_B_TO] = 1'b1;
            s_d.status[CSRB_B_PD] = 1'b0;
        end
        if (evt.wdt_timeout)
            s_d.status[CSRB_B_TO] = 1'b0;
    end

    // registers; other resets keep flags, power-on sets TO and PD and clears Z, DC and C
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q.status[7:5] <= CSRB_R_STHI;
            if (!por_n) begin
                s_q.status[CSRB_B_TO] <= 1'b1;
                s_q.status[CSRB_B_PD] <= 1'b1;
                s_q.status[2:0]       <= 3'h0;
            end
            s_q.option <= CSRB_R_OPTION;
            s_q.program_counter_low    <= CSRB_R_ZERO;
            s_q.program_counter_high_latch <= CSRB_R_ZERO;
            s_q.interrupt_control <= CSRB_R_ZERO;
            s_q.pir    <= CSRB_R_ZERO;
            s_q.pie    <= CSRB_R_ZERO;
            s_q.comparator_config  <= CSRB_R_ZERO;
            s_q.port_a_direction  <= CSRB_R_PORT_A_DIRECTION;
            s_q.port_b_direction  <= CSRB_R_PORT_B_DIRECTION;
            s_q.voltage_ref_config  <= CSRB_R_ZERO;
            s_q.power_reset_flags   <= CSRB_R_ZERO;
            s_q.rd     <= CSRB_R_ZERO;
            s_q.result <= CSRB_R_ZERO;
            if (!por_n)
                s_q.indirect_pointer <= CSRB_R_ZERO;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from state flops
    assign rd_data          = s_q.rd;
    assign status_out       = s_q.status;
    assign option_out       = s_q.option;
    assign fsr_out          = s_q.indirect_pointer;
    assign program_counter_high_latch_out       = s_q.program_counter_high_latch;
    assign result_out       = s_q.result;
    assign bank_hi          = s_q.status[CSRB_B_RP0];
    assign prescaler_assign = s_q.option[3];
endmodule // csrb_core_regs

// File: testbench/csrb_core_monitor.sv
module csrb_core_monitor
    import csrb_pkg::*;
(
    // clock and reset
    input wire logic                   mclk,
    input wire logic                   rst_n,
    input wire logic                   por_n,
    // core inputs
    input wire csrb_pkg::csrb_req_type req,
    input wire csrb_pkg::csrb_evt_type evt,
    // core state
    input wire logic [7:0]             status_out,
    input wire logic [7:0]             option_out,
    input wire logic [7:0]             result_out,
    input wire logic                   prescaler_assign
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0] sum_q;
    logic [4:0] nib_q;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // reference carries, one cycle behind the request like the flags
    always_ff @(posedge mclk) begin
        sum_q <= {1'b0, req.a} + {1'b0, req.b};
        nib_q <= {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]};
    end
    // status written by an instruction, no core event alongside
    sequence s_stwr;
        req.valid && req.write_file && req.dest[6:0] == 7'h03;
    endsequence
    sequence s_quiet;
        evt == '0;
    endsequence
    property p_timeout;
        evt.wdt_timeout |=> !status_out[4];
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag not cleared");
    property p_sleep;
        evt.sleep && !evt.wdt_timeout |=> status_out[4:3] == 2'b10;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
    property p_wclr;
        evt == 3'b010 |=> status_out[4:3] == 2'b11;
    endproperty
    a_wclr: assert property (p_wclr) else $error("watchdog clear flags wrong");
    property p_protect;
        s_stwr ##0 s_quiet |=> status_out[4:3] == $past(status_out[4:3]);
    endproperty
    a_protect: assert property (p_protect) else $error("protected flags written");
    property p_clr;
        s_stwr ##0 (req.op == CSRB_OP_CLR && req.set_z) |=> status_out[7:5] == 3'h0 && status_out[2];
    endproperty
    a_clr: assert property (p_clr) else $error("status clear wrong");
    property p_zero;
        req.valid && req.set_z |=> status_out[2] == (result_out == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_add;
        req.valid && req.op == CSRB_OP_ADD |=> status_out[1:0] == {nib_q[4], sum_q[8]};
    endproperty
    a_add: assert property (p_add) else $error("add carries wrong");
    property p_optrst;
        $rose(rst_n) |-> option_out == 8'hff && prescaler_assign;
    endproperty
    a_optrst: assert property (p_optrst) else $error("option reset wrong");
    property p_por;
        $rose(rst_n) && !$past(por_n) |-> status_out == 8'h18;
    endproperty
    a_por: assert property (p_por) else $error("power-on status wrong");
endmodule // csrb_core_monitor

bind csrb_core_regs csrb_core_monitor mon_u (.mclk(mclk), .rst_n(rst_n), .por_n(por_n), .req(req), .evt(evt),
    .status_out(status_out), .option_out(option_out), .result_out(result_out), .prescaler_assign(prescaler_assign));

// File: testbench/csrb_cpu_model.sv
module csrb_cpu_model
    import csrb_pkg::*;
(
    // clock
    input  wire logic              mclk,
    // datapath side of the core
    output csrb_pkg::csrb_req_type req,
    output csrb_pkg::csrb_evt_type evt,
    output logic [7:0]             rd_addr,
    input  wire logic [7:0]        rd_data
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle bus from time zero
    initial begin
        req = '0;
        evt = '0;
        rd_addr = 8'h00;
    end
    // one execute cycle, held across exactly one taking edge
    task automatic exec(input csrb_op_type op, input logic [7:0] a, input logic [7:0] b, input logic [7:0] d,
                        input logic sz);
        if (op == CSRB_OP_MOVE && d[6:0] == 7'h03) begin
            a[7:6] = 2'b00;
            b[7:6] = 2'b00;
        end
        @(posedge mclk);
        #1 req = '{1'b1, op, sz, a, b, d, 1'b1};
        @(posedge mclk);
        #1 req = '0;
    endtask
    // single-cycle core event
    task automatic ev(input csrb_evt_type e);
        @(posedge mclk);
        #1 evt = e;
        @(posedge mclk);
        #1 evt = '0;
    endtask
    // operand read, data one cycle after the address
    task automatic rd(input logic [7:0] ad, output logic [7:0] q);
        @(posedge mclk);
        #1 rd_addr = ad;
        @(posedge mclk);
        #1 q = rd_data;
    endtask
endmodule // csrb_cpu_model

// File: testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import csrb_pkg::*;
    typedef struct packed {
        csrb_op_type op;
        logic [7:0]  a;
        logic [7:0]  b;
        logic [7:0]  d;
        logic        sz;
        logic [7:0]  r;
        logic [7:0]  s;
    } csrb_row_type;
    logic mclk, rst_n, por_n, bank, ps;
    csrb_req_type req;
    csrb_evt_type evt;
    logic [7:0] rd_addr, rd_data, st, opt, res, indirect_pointer, pch;
    int n_fail = 0;
    int num_checks = 0;
    logic [7:0] ra [8] = '{8'h03, 8'h83, 8'h81, 8'h85, 8'h86, 8'h87, 8'h0c, 8'h9f};
    logic [7:0] rv [8] = '{8'h18, 8'h18, 8'hff, 8'h1f, 8'hff, 8'h00, 8'h00, 8'h00};
    csrb_evt_type es [4] = '{3'b100, 3'b001, 3'b010, 3'b100};
    logic [1:0] ee [4] = '{2'b01, 2'b10, 2'b11, 2'b01};
    // arithmetic and logic cases; 87h is unmapped so only the flags move, except the row aimed at status
    csrb_row_type rows [10] = '{
        '{CSRB_OP_ADD, 8'h0f, 8'h01, 8'h87, 1'b1, 8'h10, 8'h1a},
        '{CSRB_OP_ADD, 8'hf0, 8'h10, 8'h87, 1'b1, 8'h00, 8'h1d},
        '{CSRB_OP_SUB, 8'h05, 8'h05, 8'h87, 1'b1, 8'h00, 8'h1f},
        '{CSRB_OP_SUB, 8'h03, 8'h05, 8'h87, 1'b1, 8'hfe, 8'h18},
        '{CSRB_OP_RRF, 8'h01, 8'h01, 8'h87, 1'b0, 8'h00, 8'h19},
        '{CSRB_OP_RLF, 8'h01, 8'h01, 8'h87, 1'b0, 8'h03, 8'h18},
        '{CSRB_OP_ADD, 8'h80, 8'h80, 8'h83, 1'b1, 8'h00, 8'h1d},
        '{CSRB_OP_IOR, 8'h50, 8'h0a, 8'h87, 1'b1, 8'h5a, 8'h19},
        '{CSRB_OP_AND, 8'hf0, 8'h0f, 8'h87, 1'b1, 8'h00, 8'h1d},
        '{CSRB_OP_XOR, 8'h3c, 8'hff, 8'h87, 1'b1, 8'hc3, 8'h19}};

    csrb_core_regs dut_u (.mclk(mclk), .rst_n(rst_n), .por_n(por_n), .req(req), .evt(evt), .rd_addr(rd_addr),
        .rd_data(rd_data), .status_out(st), .option_out(opt), .fsr_out(indirect_pointer), .program_counter_high_latch_out(pch), .result_out(res),
        .bank_hi(bank), .prescaler_assign(ps));
    csrb_cpu_model cpu_u (.mclk(mclk), .req(req), .evt(evt), .rd_addr(rd_addr), .rd_data(rd_data));

    // 200 MHz clock
    initial begin
        mclk = 0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
        logic [7:0] q;
        cpu_u.rd(ad, q);
        chk("read", q, exp);
    endtask
    // plain move; touches no flag, so safe for status
    task automatic mv(input logic [7:0] d, input logic [7:0] x);
        cpu_u.exec(CSRB_OP_MOVE, x, x, d, 1'b0);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // hang guard, far above the fewer than one hundred cycles used
    initial begin
        #20000;
        n_fail++;
        test_done();
    end
    initial begin
        rst_n = 0;
        por_n = 0;
        repeat (20) @(posedge mclk);
        #1 rst_n = 1;
        por_n = 1;
        foreach (ra[i]) rdc(ra[i], rv[i]);
        chk("prescaler", {7'h00, ps}, 8'h01);
        chk("option", opt, 8'hff);
        chk("fsr", indirect_pointer, 8'h00);
        $display("reset values done");
        mv(CSRB_A_STATUS1, 8'he5);
        chk("status", st, 8'h3d);
        chk("bank", {7'h00, bank}, 8'h01);
        rdc(CSRB_A_STATUS0, 8'h3d);
        mv(CSRB_A_PCLATH0, 8'hff);
        rdc(CSRB_A_PCLATH1, 8'h1f);
        chk("program_counter_high_latch", pch, 8'h1f);
        mv(CSRB_A_FSR1, 8'ha5);
        chk("fsr", indirect_pointer, 8'ha5);
        rdc(CSRB_A_FSR0, 8'ha5);
        mv(8'h87, 8'h5a);
        rdc(8'h87, 8'h00);
        mv(CSRB_A_OPTION, 8'h00);
        chk("prescaler", {7'h00, ps}, 8'h00);
        chk("option", opt, 8'h00);
        cpu_u.exec(CSRB_OP_CLR, 8'h00, 8'h00, CSRB_A_STATUS0, 1'b1);
        chk("status", st, 8'h1d);
        chk("bank", {7'h00, bank}, 8'h00);
        $display("writes done");
        foreach (rows[i]) begin
            cpu_u.exec(rows[i].op, rows[i].a, rows[i].b, rows[i].d, rows[i].sz);
            chk("result", res, rows[i].r);
            chk("flags", st, rows[i].s);
        end
        $display("arithmetic done");
        foreach (es[i]) begin
            cpu_u.ev(es[i]);
            chk("events", {6'h00, st[4:3]}, {6'h00, ee[i]});
        end
        mv(CSRB_A_STATUS0, 8'h18);
        chk("status", st, 8'h08);
        mv(CSRB_A_STATUS1, 8'h27);
        chk("status", st, 8'h2f);
        @(posedge mclk);
        #1 rst_n = 0;
        repeat (2) @(posedge mclk);
        #1 rst_n = 1;
        chk("status", st, 8'h0f);
        chk("fsr", indirect_pointer, 8'ha5);
        chk("option", opt, 8'hff);
        rdc(CSRB_A_OPTION, 8'hff);
        $display("events and warm reset done");
        test_done();
    end
endmodule // testbench
